// ==== osd_pkg.sv ====
// Purpose: Shared constants and types for the serial display register loader
// Assumes: 16-bit display words, 4-bit row and 5-bit column indices
// Notes:   Word layout is row, column, font top bit, then the data word
package osd_pkg;
  localparam logic [7:0] ADDR_WRITE = 8'hba;
  localparam logic [7:0] ADDR_READ  = 8'hbb;

  localparam int ROW_W  = 4;
  localparam int COL_W  = 5;
  localparam int DATA_W = 16;
  localparam int WORD_W = ROW_W + COL_W + 1 + DATA_W;

  // Positions inside a received word
  localparam int WORD_DATA_LSB = 0;
  localparam int WORD_TOP_BIT  = 16;
  localparam int WORD_COL_LSB  = 17;
  localparam int WORD_ROW_LSB  = 22;

  // Positions inside the row and column address bytes
  localparam int ROWB_COLUMN_FORMAT_ENABLE_BIT = 7;
  localparam int COLB_TOP_BIT   = 7;

  // Polarity control word and its fields
  localparam logic [3:0] POL_ROW     = 4'hf;
  localparam logic [4:0] POL_COL     = 5'h01;
  localparam int         HPOL_BIT    = 7;
  localparam int         VPOL_BIT    = 6;
  localparam logic       POL_RESET   = 1'b0;

  localparam logic [3:0] BYTE_BITS   = 4'h8;
  localparam int         FIFO_DEPTH  = 8;

  // Synchroniser lanes
  localparam int PIN_SCL = 0;
  localparam int PIN_SDA = 1;
  localparam int PIN_HFB = 2;
  localparam int PIN_VFB = 3;
  localparam int PIN_N   = 4;

  typedef enum logic [6:0] {
    S_IDLE = 7'h01,
    S_ADDR = 7'h02,
    S_ROW  = 7'h04,
    S_COL  = 7'h08,
    S_DHI  = 7'h10,
    S_DLO  = 7'h20,
    S_SKIP = 7'h40
  } osd_state_type;
endpackage

// ==== osd_word_if.sv ====
// Purpose: Valid/ready carrier for received display words
// Assumes: Source holds data stable while valid is high and ready is low
// Notes:   One word moves on each clock with valid and ready both high
`timescale 1ns/1ps
interface osd_word_if #(parameter int W = 26) ();
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// ==== osd_word_fifo.sv ====
// Purpose: Flip-flop FIFO for received display words
// Assumes: DEPTH is a power of two
// Notes:   Full and empty come from pointers with one extra wrap bit
`timescale 1ns/1ps
module osd_word_fifo #(
  parameter int WIDTH = 26,
  parameter int DEPTH = 8
) (
  input wire logic mclk,
  input wire logic rst_b,
  osd_word_if.snk  fill,
  osd_word_if.src  drain
);
  localparam int AW = $clog2(DEPTH);

  if ((DEPTH < 2) || (DEPTH != (1 << AW))) begin : g_chk
    $error("DEPTH must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] mem_d [DEPTH];
  logic [AW:0]      wrPtr_q;
  logic [AW:0]      wrPtr_d;
  logic [AW:0]      rdPtr_q;
  logic [AW:0]      rdPtr_d;
  logic             full;
  logic             empty;

  assign full  = (wrPtr_q[AW] != rdPtr_q[AW]) &&
                 (wrPtr_q[AW-1:0] == rdPtr_q[AW-1:0]);
  assign empty = (wrPtr_q == rdPtr_q);
  assign fill.ready  = !full;
  assign drain.valid = !empty;
  assign drain.data  = mem_q[rdPtr_q[AW-1:0]];

  always_comb begin
    mem_d   = mem_q;
    wrPtr_d = wrPtr_q;
    rdPtr_d = rdPtr_q;
    if (fill.valid && !full) begin
      mem_d[wrPtr_q[AW-1:0]] = fill.data;
      wrPtr_d = wrPtr_q + 1'b1;
    end
    if (drain.valid && drain.ready) begin
      rdPtr_d = rdPtr_q + 1'b1;
    end
  end

  // Storage carries no reset; only the pointers decide what is valid
  always_ff @(posedge mclk) begin
    mem_q <= mem_d;
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
    end else begin
      wrPtr_q <= wrPtr_d;
      rdPtr_q <= rdPtr_d;
    end
  end
endmodule

// ==== osd_serial_display_register_loader.sv ====
// Purpose: Two-wire write receiver that loads 16-bit display words
// Assumes: mclk at 20 MHz, well above the bus clock; rst_b synchronous
// Notes:   Holds the bus clock low while a finished word waits on the full word FIFO
//
// Function
// (RQ1) A write runs start, address byte, row byte, column byte, two data bytes, stop.
// (RQ2) Every byte of a write, address and data alike, is acknowledged by the device.
// (RQ3) The device answers bus address BAh for writes and BBh for reads only.
// (RQ4) Each pair of data bytes becomes one 16-bit word, in either of two formats.
// (RQ5) The font index has nine bits, eight from the data word and one from the column byte.
// (RQ6) The column byte's top bit counts as font index bit only with column format on.
// (RQ7) Row byte bits 3 to 0 give the row index and its bits 6 and 5 are ignored.
// (RQ8) Column byte bits 4 to 0 give the column index and its bits 6 and 5 are ignored.
// (RQ9) Row byte bit 7 switches the column-oriented format on.
// (RQ10) In column format one row byte is followed by column-and-two-data groups until stop.
// (RQ11) The intensity output is high while an intensity-marked character or raster shows.
// (RQ12) Intensity with the three colour outputs encodes sixteen colours.
// (RQ13) Flyback inputs are active low after reset and a control word can flip them.
// (RQ14) The master changes the data line only while the clock is low, save start and stop.
// (RQ15) The serial stream is turned into 16-bit words passed on over an internal bus.
// (RQ16) In auto-increment format the column advances by one after every data word.
// (RQ17) The first data byte is the upper attribute half, the second the character code.
`timescale 1ns/1ps
module osd_serial_display_register_loader (
  input  wire logic        mclk,
  input  wire logic        rst_b,
  input  wire logic        sclIn,
  output logic             sclOut,
  output logic             sclOe_b,
  input  wire logic        sdaIn,
  output logic             sdaOut,
  output logic             sdaOe_b,
  input  wire logic        horizontalFlybackIn,
  input  wire logic        verticalFlybackIn,
  output logic             hFlybackActive,
  output logic             vFlybackActive,
  input  wire logic        pixelActive,
  input  wire logic        pixelIntensity,
  input  wire logic [2:0]  pixelRgb,
  output logic             redOut,
  output logic             greenOut,
  output logic             blueOut,
  output logic             intensityOut,
  output logic             fastBlankOut,
  output logic             wrValid,
  input  wire logic        wrReady,
  output logic [3:0]       wrRowIndex,
  output logic [4:0]       wrColumnIndex,
  output logic             wrFontIndexTopBit,
  output logic [15:0]      wrData
);
  localparam int N = osd_pkg::PIN_N;
  localparam int W = osd_pkg::WORD_W;

  // Input synchronisers and edge detection
  logic [N-1:0] stage1_q;
  logic [N-1:0] stage2_q;
  logic [N-1:0] stage3_q;
  logic [N-1:0] clean_q;
  logic [N-1:0] clean_d;

  always_comb begin
    clean_d = clean_q;
    for (int i = 0; i < N; i++) begin
      if (stage2_q[i] == stage3_q[i]) begin
        clean_d[i] = stage3_q[i];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      stage1_q <= '1;
      stage2_q <= '1;
      stage3_q <= '1;
      clean_q  <= '1;
    end else begin
      stage1_q <= {verticalFlybackIn, horizontalFlybackIn, sdaIn, sclIn};
      stage2_q <= stage1_q;
      stage3_q <= stage2_q;
      clean_q  <= clean_d;
    end
  end

  logic sclRise;
  logic sclFall;
  logic startSeen;
  logic stopSeen;
  logic sclNow;
  logic sdaNow;
  logic sdaWas;

  // Edges come from the settling value: a short bus low phase leaves no
  // spare clock, and a later ack would move data with the clock high
  assign sclNow  = clean_d[osd_pkg::PIN_SCL];
  assign sdaNow  = clean_d[osd_pkg::PIN_SDA];
  assign sdaWas  = clean_q[osd_pkg::PIN_SDA];
  assign sclRise = sclNow && !clean_q[osd_pkg::PIN_SCL];
  assign sclFall = !sclNow && clean_q[osd_pkg::PIN_SCL];
  // Data may move only with the clock low, so a move with it high frames
  assign startSeen = sclNow && clean_q[osd_pkg::PIN_SCL]
                     && sdaWas && !sdaNow; // RQ14
  assign stopSeen  = sclNow && clean_q[osd_pkg::PIN_SCL]
                     && !sdaWas && sdaNow; // RQ14

  // Protocol state
  osd_word_if #(.W(W)) pushIf ();
  osd_word_if #(.W(W)) popIf ();

  osd_pkg::osd_state_type state_q;
  osd_pkg::osd_state_type state_d;
  logic [3:0]  bitCnt_q;
  logic [3:0]  bitCnt_d;
  logic [7:0]  shift_q;
  logic [7:0]  shift_d;
  logic        ackPhase_q;
  logic        ackPhase_d;
  logic        sdaOe_b_d;
  logic        column_format_enable_q;
  logic        column_format_enable_d;
  logic [3:0]  row_q;
  logic [3:0]  row_d;
  logic [4:0]  col_q;
  logic [4:0]  col_d;
  logic        top_q;
  logic        top_d;
  logic [7:0]  hi_q;
  logic [7:0]  hi_d;
  logic        pushPend_q;
  logic        pushPend_d;
  logic [W-1:0] pushWord_q;
  logic [W-1:0] pushWord_d;
  logic        byteDone;

  assign byteDone = sclFall && !ackPhase_q && (bitCnt_q == osd_pkg::BYTE_BITS)
                    && (state_q != osd_pkg::S_IDLE);

  always_comb begin
    state_d    = state_q;
    bitCnt_d   = bitCnt_q;
    shift_d    = shift_q;
    ackPhase_d = ackPhase_q;
    sdaOe_b_d  = sdaOe_b;
    column_format_enable_d    = column_format_enable_q;
    row_d      = row_q;
    col_d      = col_q;
    top_d      = top_q;
    hi_d       = hi_q;
    pushPend_d = pushPend_q && !pushIf.ready;
    pushWord_d = pushWord_q;
    if (startSeen) begin
      state_d    = osd_pkg::S_ADDR; // RQ1
      bitCnt_d   = 4'h0;
      ackPhase_d = 1'b0;
      sdaOe_b_d  = 1'b1;
    end else if (stopSeen) begin
      state_d    = osd_pkg::S_IDLE; // RQ1
      ackPhase_d = 1'b0;
      sdaOe_b_d  = 1'b1;
    end else if (sclRise && !ackPhase_q && state_q != osd_pkg::S_IDLE) begin
      shift_d  = {shift_q[6:0], sdaNow};
      bitCnt_d = bitCnt_q + 4'h1;
    end else if (sclFall && ackPhase_q) begin
      ackPhase_d = 1'b0;
      sdaOe_b_d  = 1'b1;
      bitCnt_d   = 4'h0;
    end else if (byteDone) begin
      bitCnt_d   = 4'h0;
      ackPhase_d = 1'b1; // RQ2
      sdaOe_b_d  = 1'b0; // RQ2
      case (state_q)
        osd_pkg::S_ADDR: begin
          if (shift_q == osd_pkg::ADDR_WRITE) begin
            state_d = osd_pkg::S_ROW; // RQ3
          end else begin
            // Reads are acknowledged and then the line is left released
            state_d = osd_pkg::S_SKIP;
            if (shift_q != osd_pkg::ADDR_READ) begin
              ackPhase_d = 1'b0; // RQ3
              sdaOe_b_d  = 1'b1;
            end
          end
        end
        osd_pkg::S_ROW: begin
          column_format_enable_d = shift_q[osd_pkg::ROWB_COLUMN_FORMAT_ENABLE_BIT]; // RQ9
          row_d   = shift_q[3:0]; // RQ7
          state_d = osd_pkg::S_COL;
        end
        osd_pkg::S_COL: begin
          col_d   = shift_q[4:0]; // RQ8
          top_d   = shift_q[osd_pkg::COLB_TOP_BIT];
          state_d = osd_pkg::S_DHI;
        end
        osd_pkg::S_DHI: begin
          hi_d    = shift_q; // RQ17
          state_d = osd_pkg::S_DLO;
        end
        osd_pkg::S_DLO: begin
          pushPend_d = 1'b1; // RQ15
          pushWord_d = {row_q, col_q, column_format_enable_q && top_q, hi_q, shift_q}; // RQ4 RQ5 RQ6 RQ17
          if (column_format_enable_q) begin
            state_d = osd_pkg::S_COL; // RQ10
          end else begin
            col_d   = col_q + 5'h01; // RQ16
            state_d = osd_pkg::S_DHI; // RQ4
          end
        end
        default: begin
          ackPhase_d = 1'b0;
          sdaOe_b_d  = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      state_q    <= osd_pkg::S_IDLE;
      bitCnt_q   <= 4'h0;
      shift_q    <= 8'h00;
      ackPhase_q <= 1'b0;
      sdaOe_b    <= 1'b1;
      column_format_enable_q    <= 1'b0;
      row_q      <= 4'h0;
      col_q      <= 5'h00;
      top_q      <= 1'b0;
      hi_q       <= 8'h00;
      pushPend_q <= 1'b0;
      pushWord_q <= '0;
      sclOe_b    <= 1'b1;
      sdaOut     <= 1'b0;
      sclOut     <= 1'b0;
    end else begin
      state_q    <= state_d;
      bitCnt_q   <= bitCnt_d;
      shift_q    <= shift_d;
      ackPhase_q <= ackPhase_d;
      sdaOe_b    <= sdaOe_b_d;
      column_format_enable_q    <= column_format_enable_d;
      row_q      <= row_d;
      col_q      <= col_d;
      top_q      <= top_d;
      hi_q       <= hi_d;
      pushPend_q <= pushPend_d;
      pushWord_q <= pushWord_d;
      // Stretching the clock instead of refusing the word keeps every ack
      sclOe_b    <= !(pushPend_d && !pushIf.ready);
      sdaOut     <= 1'b0;
      sclOut     <= 1'b0;
    end
  end

  assign pushIf.valid = pushPend_q;
  assign pushIf.data  = pushWord_q;

  osd_word_fifo #(
    .WIDTH (W),
    .DEPTH (osd_pkg::FIFO_DEPTH)
  ) u_fifo (
    .mclk  (mclk),
    .rst_b (rst_b),
    .fill  (pushIf),
    .drain (popIf)
  );

  // Output stage, flyback polarity and pixel outputs
  logic         outValid_d;
  logic [W-1:0] outWord_q;
  logic [W-1:0] outWord_d;
  logic         hPolHigh_q;
  logic         hPolHigh_d;
  logic         vPolHigh_q;
  logic         vPolHigh_d;
  logic         popTake;

  assign popIf.ready = !wrValid || wrReady;
  assign popTake     = popIf.valid && popIf.ready;

  always_comb begin
    outValid_d = wrValid && !wrReady;
    outWord_d  = outWord_q;
    hPolHigh_d = hPolHigh_q;
    vPolHigh_d = vPolHigh_q;
    if (popTake) begin
      outValid_d = 1'b1; // RQ15
      outWord_d  = popIf.data;
      if (popIf.data[osd_pkg::WORD_ROW_LSB +: 4] == osd_pkg::POL_ROW &&
          popIf.data[osd_pkg::WORD_COL_LSB +: 5] == osd_pkg::POL_COL) begin
        hPolHigh_d = popIf.data[osd_pkg::HPOL_BIT]; // RQ13
        vPolHigh_d = popIf.data[osd_pkg::VPOL_BIT]; // RQ13
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      wrValid        <= 1'b0;
      outWord_q      <= '0;
      hPolHigh_q     <= osd_pkg::POL_RESET; // RQ13
      vPolHigh_q     <= osd_pkg::POL_RESET; // RQ13
      hFlybackActive <= 1'b0;
      vFlybackActive <= 1'b0;
      intensityOut   <= 1'b0;
      redOut         <= 1'b0;
      greenOut       <= 1'b0;
      blueOut        <= 1'b0;
      fastBlankOut   <= 1'b0;
    end else begin
      wrValid        <= outValid_d;
      outWord_q      <= outWord_d;
      hPolHigh_q     <= hPolHigh_d;
      vPolHigh_q     <= vPolHigh_d;
      hFlybackActive <= clean_q[osd_pkg::PIN_HFB] == hPolHigh_q; // RQ13
      vFlybackActive <= clean_q[osd_pkg::PIN_VFB] == vPolHigh_q; // RQ13
      intensityOut   <= pixelActive && pixelIntensity; // RQ11 RQ12
      redOut         <= pixelActive && pixelRgb[0]; // RQ12
      greenOut       <= pixelActive && pixelRgb[1]; // RQ12
      blueOut        <= pixelActive && pixelRgb[2]; // RQ12
      fastBlankOut   <= pixelActive;
    end
  end

  assign wrRowIndex        = outWord_q[osd_pkg::WORD_ROW_LSB +: 4];
  assign wrColumnIndex     = outWord_q[osd_pkg::WORD_COL_LSB +: 5];
  assign wrFontIndexTopBit = outWord_q[osd_pkg::WORD_TOP_BIT];
  assign wrData            = outWord_q[osd_pkg::WORD_DATA_LSB +: 16];

  // Checks
  sequence s_data_done;
    byteDone && state_q == osd_pkg::S_DLO;
  endsequence

  property p_ack_data;
    @(posedge mclk) disable iff (!rst_b)
    byteDone && state_q != osd_pkg::S_ADDR && state_q != osd_pkg::S_SKIP
    |=> !sdaOe_b && ackPhase_q;
  endproperty
  a_ack_data: assert property (p_ack_data) else $error("byte not acked"); // RQ2

  property p_addr_match;
    @(posedge mclk) disable iff (!rst_b)
    byteDone && state_q == osd_pkg::S_ADDR &&
    shift_q != osd_pkg::ADDR_WRITE && shift_q != osd_pkg::ADDR_READ
    |=> sdaOe_b && state_q == osd_pkg::S_SKIP;
  endproperty
  a_addr_match: assert property (p_addr_match) else $error("foreign ack"); // RQ3

  property p_format_next;
    @(posedge mclk) disable iff (!rst_b)
    s_data_done |=> state_q == ($past(column_format_enable_q) ? osd_pkg::S_COL
                                               : osd_pkg::S_DHI);
  endproperty
  a_format_next: assert property (p_format_next) else $error("bad order"); // RQ10

  property p_col_step;
    @(posedge mclk) disable iff (!rst_b)
    s_data_done ##0 !column_format_enable_q |=> col_q == $past(col_q) + 5'h01;
  endproperty
  a_col_step: assert property (p_col_step) else $error("no column step"); // RQ16

  property p_word_pair;
    @(posedge mclk) disable iff (!rst_b)
    s_data_done |=> pushPend_q && pushWord_q[15:0] == {$past(hi_q),
                                                       $past(shift_q)};
  endproperty
  a_word_pair: assert property (p_word_pair) else $error("word mispaired"); // RQ17

  property p_font_top;
    @(posedge mclk) disable iff (!rst_b)
    s_data_done |=> pushWord_q[osd_pkg::WORD_TOP_BIT] ==
                    ($past(column_format_enable_q) && $past(top_q));
  endproperty
  a_font_top: assert property (p_font_top) else $error("bad font bit"); // RQ6

  property p_row_fields;
    @(posedge mclk) disable iff (!rst_b)
    byteDone && state_q == osd_pkg::S_ROW
    |=> row_q == $past(shift_q[3:0]) && column_format_enable_q == $past(shift_q[7]);
  endproperty
  a_row_fields: assert property (p_row_fields) else $error("bad row"); // RQ7

  property p_out_hold;
    @(posedge mclk) disable iff (!rst_b)
    wrValid && !wrReady |=> wrValid && $stable(wrData) && $stable(wrRowIndex);
  endproperty
  a_out_hold: assert property (p_out_hold) else $error("word dropped"); // RQ15

  property p_intensity;
    @(posedge mclk) disable iff (!rst_b)
    pixelActive && pixelIntensity ##1 1'b1 |-> intensityOut;
  endproperty
  a_intensity: assert property (p_intensity) else $error("no intensity"); // RQ11

  property p_pol_reset;
    @(posedge mclk) $past(!rst_b) && rst_b |-> !hPolHigh_q && !vPolHigh_q;
  endproperty
  a_pol_reset: assert property (p_pol_reset) else $error("bad polarity"); // RQ13
endmodule

// ==== osd_host_model.sv ====
// Purpose: Two-wire bus master that writes display words into the device
// Assumes: Both lines have pull-ups; the bench resolves the wire levels
// Notes:   Timing runs on its own delays, unrelated to mclk
`timescale 1ns/1ps
module osd_host_model (
  output logic      sclDrive,
  output logic      sdaDrive,
  input  wire logic sclWire,
  input  wire logic sdaWire
);
  localparam int HALF = 200;

  initial begin
    sclDrive = 1'b1;
    sdaDrive = 1'b1;
  end

  // Release the clock and wait out any stretch before timing the high phase
  task automatic clockHigh();
    int n;
    n = 0;
    sclDrive = 1'b1;
    while (sclWire !== 1'b1 && n < 20000) begin
      #10;
      n++;
    end
    #HALF;
  endtask

  task automatic sendStart();
    #(HALF / 2);
    sdaDrive = 1'b1;
    #(HALF / 2);
    clockHigh();
    sdaDrive = 1'b0;
    #HALF;
    sclDrive = 1'b0;
  endtask

  // Data only moves in mid low phase, well clear of both clock edges
  task automatic sendByte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      #(HALF / 2);
      sdaDrive = b[i];
      #(HALF / 2);
      clockHigh();
      sclDrive = 1'b0;
    end
    #(HALF / 2);
    sdaDrive = 1'b1;
    #(HALF / 2);
    clockHigh();
    ack = (sdaWire === 1'b0);
    sclDrive = 1'b0;
  endtask

  task automatic sendStop();
    #(HALF / 2);
    sdaDrive = 1'b0;
    #(HALF / 2);
    clockHigh();
    sdaDrive = 1'b1;
    #(2 * HALF);
  endtask
endmodule

// ==== osd_serial_display_register_loader_tb.sv ====
// Purpose: Self-checking bench for the serial display register loader
// Assumes: Host model as bus master, random sink stalls and pixel stimulus
// Notes:   Expected words queue up at the driver, a monitor pops them
`timescale 1ns/1ps
module osd_serial_display_register_loader_tb;
  logic        mclk = 1'b0;
  logic        rst_b, sclWire, sdaWire, sclDrive, sdaDrive;
  logic        sclOut, sclOe_b, sdaOut, sdaOe_b;
  logic        hFb, vFb, hAct, vAct, pixA, pixI, pixA_q, pixI_q;
  logic [2:0]  pixRgb, pixRgb_q;
  logic        redOut, greenOut, blueOut, intensityOut, fastBlankOut;
  logic        wrValid, wrReady, wrTop, stall, pixCheck;
  logic        sawStretch = 1'b0;
  logic [3:0]  wrRow;
  logic [4:0]  wrCol;
  logic [15:0] wrData;
  logic [25:0] expQ[$];
  int          seed, miscompares, n_checks;

  always #25 mclk = ~mclk;
  assign sclWire = sclDrive & (sclOe_b | sclOut);
  assign sdaWire = sdaDrive & (sdaOe_b | sdaOut);

  osd_host_model host (.sclDrive(sclDrive), .sdaDrive(sdaDrive),
    .sclWire(sclWire), .sdaWire(sdaWire));

  osd_serial_display_register_loader dut (.mclk(mclk), .rst_b(rst_b),
    .sclIn(sclWire), .sclOut(sclOut), .sclOe_b(sclOe_b),
    .sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOe_b(sdaOe_b),
    .horizontalFlybackIn(hFb), .verticalFlybackIn(vFb),
    .hFlybackActive(hAct), .vFlybackActive(vAct),
    .pixelActive(pixA), .pixelIntensity(pixI), .pixelRgb(pixRgb),
    .redOut(redOut), .greenOut(greenOut), .blueOut(blueOut),
    .intensityOut(intensityOut), .fastBlankOut(fastBlankOut),
    .wrValid(wrValid), .wrReady(wrReady), .wrRowIndex(wrRow),
    .wrColumnIndex(wrCol), .wrFontIndexTopBit(wrTop), .wrData(wrData));

  task automatic check(input string what, input logic [25:0] seen,
                       input logic [25:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic print_verdict();
    if (miscompares == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic sendChecked(input logic [7:0] b, input logic expAck);
    logic ack;
    host.sendByte(b, ack);
    check("ack", {25'h0, ack}, {25'h0, expAck});
  endtask

  // Column format sends a fresh column byte per word, else one up front
  task automatic writeWords(input logic [7:0] rowB, input logic [7:0] colB,
                            input int n, input logic [15:0] orMask);
    logic [7:0]  c;
    logic [15:0] d;
    logic [4:0]  col;
    host.sendStart();
    sendChecked(osd_pkg::ADDR_WRITE, 1'b1);
    sendChecked(rowB, 1'b1);
    c = colB;
    if (!rowB[7]) sendChecked(c, 1'b1);
    for (int k = 0; k < n; k++) begin
      d = 16'($random(seed)) | orMask;
      if (rowB[7]) c = 8'($random(seed)) | ((k == 0) ? 8'h80 : 8'h00);
      col = rowB[7] ? c[4:0] : colB[4:0] + 5'(k);
      expQ.push_back({rowB[3:0], col, rowB[7] & c[7], d});
      if (rowB[7]) sendChecked(c, 1'b1);
      sendChecked(d[15:8], 1'b1);
      sendChecked(d[7:0], 1'b1);
    end
    host.sendStop();
  endtask

  always @(posedge mclk) begin
    #2;
    {pixA, pixI, pixRgb} <= 5'($random(seed));
    wrReady <= stall ? 1'b0 : 1'($random(seed));
  end

  always @(posedge mclk) begin
    if (sclOe_b === 1'b0) sawStretch <= 1'b1;
    if (pixCheck)
      check("pixel", {21'h0, redOut, greenOut, blueOut, intensityOut,
        fastBlankOut}, {21'h0, pixA_q & pixRgb_q[0], pixA_q & pixRgb_q[1],
        pixA_q & pixRgb_q[2], pixA_q & pixI_q, pixA_q});
    {pixA_q, pixI_q, pixRgb_q} <= {pixA, pixI, pixRgb};
    if (rst_b && wrValid === 1'b1 && wrReady === 1'b1) begin
      if (expQ.size() == 0)
        check("spare word", {wrRow, wrCol, wrTop, wrData}, 26'h0);
      else
        check("word", {wrRow, wrCol, wrTop, wrData}, expQ.pop_front());
    end
  end

  initial begin
    #3000000;
    miscompares++;
    print_verdict();
  end

  initial begin
    seed = 86982;
    // Flyback pins start at their idle high level
    {rst_b, stall, pixCheck, hFb, vFb, wrReady} = 6'h07;
    {pixA, pixI, pixRgb} = 5'h00;
    repeat (8) @(posedge mclk);
    #2 rst_b = 1'b1;
    repeat (10) @(posedge mclk);
    #2;
    check("reset", {21'h0, sdaOe_b, sclOe_b, wrValid, hAct, vAct},
      26'h18);
    pixCheck = 1'b1;
    {hFb, vFb} = 2'b00;
    repeat (10) @(posedge mclk);
    check("flyback low", {24'h0, hAct, vAct}, 26'h3);
    #7;
    writeWords(8'h63, 8'he5, 3, 16'h0);
    writeWords(8'hea, 8'h00, 4, 16'h0);
    host.sendStart();
    sendChecked(8'ha4, 1'b0);
    sendChecked(8'h55, 1'b0);
    host.sendStop();
    host.sendStart();
    sendChecked(osd_pkg::ADDR_READ, 1'b1);
    host.sendStop();
    stall = 1'b1;
    fork
      writeWords(8'h07, 8'h00, 10, 16'h0);
      begin
        repeat (2000) @(posedge mclk);
        #2 stall = 1'b0;
      end
    join
    check("stretch", {25'h0, sawStretch}, 26'h1);
    writeWords(8'h0f, 8'h01, 1, 16'h00c0);
    for (int i = 0; i < 400 && expQ.size() != 0; i++) @(posedge mclk);
    repeat (10) @(posedge mclk);
    #2;
    check("flyback high pol", {24'h0, hAct, vAct}, 26'h0);
    {hFb, vFb} = 2'b11;
    repeat (10) @(posedge mclk);
    check("flyback high", {24'h0, hAct, vAct}, 26'h3);
    check("words left", 26'(expQ.size()), 26'h0);
    print_verdict();
  end
endmodule
